// *** hdl/eifp_flags.sv ***
// per-channel request flags: sensing, read-then-write clear, auto clear
`timescale 1ns/1ps
`default_nettype none
`include "eifp_defs.svh"
module eifp_flags
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  eifp_chan_if.chan   ch
);
  import eifp_pkg::*;

  eifp_chan_type line_prev;
  eifp_chan_type arm;
  eifp_chan_type flag;
  eifp_chan_type set_cond;
  eifp_chan_type clr_cond;

  assign ch.flag    = flag;
  assign ch.set_evt = set_cond & ~flag;

  //////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < `EIFP_NCH; i = i + 1)
    begin : g_ch
      // set: low level, or a high-to-low step on the synced line
      assign set_cond[i] =
        (!ch.sense[i] && !ch.line_sync[i]) ||
        (ch.sense[i] && line_prev[i] && !ch.line_sync[i]);
      // clear: armed write of 0, or exception handling taken
      assign clr_cond[i] =
        (ch.wr_strobe && !ch.wr_data[i] && arm[i]) ||
        (ch.exc_ack[i] && !ch.sense[i] && ch.line_sync[i]) ||
        (ch.exc_ack[i] && ch.sense[i]);
    end
  endgenerate

  // flag state; a set in the clearing cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flag <= `EIFP_RST_CHAN;
    else
      flag <= set_cond | (flag & ~clr_cond);
  end

  // arm bits record a read that saw 1; a later write to the flags register with byte lane 0 strobed disarms
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      arm <= `EIFP_RST_CHAN;
    else if (ch.rd_strobe)
      arm <= flag;
    else if (ch.wr_strobe)
      arm <= `EIFP_RST_CHAN;
    else
      arm <= arm & flag;
  end

  // previous line level for edge detection; idle lines sit high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_prev <= `EIFP_RST_LINE;
    else
      line_prev <= ch.line_sync;
  end
endmodule
`default_nettype wire

// *** hdl/eifp_top.sv ***
// external irq flags, enables, sensing and priority with an axi4-lite port
`timescale 1ns/1ps
`default_nettype none
`include "eifp_defs.svh"

// Functional notes
// - a channel is masked while its enable bit is 0, allowed at 1.
// - sense bit 0: flag sets whenever the synced request line is low.
// - sense bit 1: flag sets on a high-to-low step of the line.
// - a flag clears on write 0 only after a read that saw 1.
// - level mode: exception handling with line high clears the flag.
// - edge mode: exception handling for the channel clears the flag.
// - writing 1 never sets a flag; flags reset 0; top bits unused.
// - priority bit 0 means level 0 (low), 1 means level 1 (high).
// - priority a: bits 7..3 ch0,ch1,ch2+3,ch4,watchdog; 2..0 timers 0-2.
// - priority b: 7,6 timers 3,4; 3 serial; 1 converter; rest unused.
// - sense bit 0 selects low level, 1 falling edge; resets 0.
module eifp_top
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [31:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output eifp_pkg::eifp_resp_type      s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [31:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output eifp_pkg::eifp_resp_type      s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire eifp_pkg::eifp_chan_type ext_request_line_n,
  input  wire eifp_pkg::eifp_chan_type exc_ack,
  output eifp_pkg::eifp_chan_type      irq_req,
  output eifp_pkg::eifp_chan_type      irq_prio,
  output logic                         watchdog_source_prio,
  output logic [4:0]                   timer_unit_source_prio,
  output logic                         serial_channel_source_prio,
  output logic                         converter_source_prio,
  output logic                         irq_out
);
  import eifp_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // declarations
  eifp_chan_if chif ();
  eifp_chan_type ext_request_sense_sel;
  eifp_chan_type ext_request_enable;
  eifp_byte_type priority_level_a;
  eifp_byte_type priority_level_b;
  eifp_chan_type evt_status;
  eifp_chan_type evt_mask;
  eifp_chan_type line_meta;
  eifp_chan_type line_sync;
  logic          aw_held;
  logic          w_held;
  logic [31:0]   aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          wr_fire;
  logic          rd_fire;
  logic          wr_lane0;
  logic          wr_mapped;
  logic          rd_mapped;
  logic [7:0]    next_rdata;
  eifp_chan_type ext_request_flag;

  //////////////////////////////////////////////////////////////////////
  // decode helpers
  // true when a byte address lands on the given register index
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[`EIFP_ADDR_MSB:`EIFP_ADDR_LSB] == idx) &&
              (addr[31:`EIFP_ADDR_MSB+1] == '0);
  endfunction
  // true when a byte address lands on any implemented register
  function automatic logic reg_mapped(input logic [31:0] addr);
    reg_mapped = reg_hit(addr, `EIFP_IDX_SENSE)    ||
                 reg_hit(addr, `EIFP_IDX_ENABLE)   ||
                 reg_hit(addr, `EIFP_IDX_FLAGS)    ||
                 reg_hit(addr, `EIFP_IDX_PRIO_A)   ||
                 reg_hit(addr, `EIFP_IDX_PRIO_B)   ||
                 reg_hit(addr, `EIFP_IDX_EVT_STAT) ||
                 reg_hit(addr, `EIFP_IDX_EVT_MASK);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // request line synchroniser; the pins are asynchronous to aclk
  // two stages, only the second is read by logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_meta <= `EIFP_RST_LINE;
      line_sync <= `EIFP_RST_LINE;
    end
    else
    begin
      line_meta <= ext_request_line_n;
      line_sync <= line_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane0      = wr_fire && w_strb[0];
  assign wr_mapped     = reg_mapped(aw_addr);

  // hold the address until its partner has arrived
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  // hold the data until its partner has arrived
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  // response one cycle after the write is performed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= EIFP_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? EIFP_RESP_OKAY : EIFP_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // software registers; only the low byte lane carries data
  // sense select, enable and event mask; upper bits read as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_request_sense_sel <= `EIFP_RST_CHAN;
      ext_request_enable    <= `EIFP_RST_CHAN;
      evt_mask              <= `EIFP_RST_CHAN;
    end
    else if (wr_lane0)
    begin
      if (reg_hit(aw_addr, `EIFP_IDX_SENSE))
        ext_request_sense_sel <= w_data[4:0];
      if (reg_hit(aw_addr, `EIFP_IDX_ENABLE))
        ext_request_enable <= w_data[4:0];
      if (reg_hit(aw_addr, `EIFP_IDX_EVT_MASK))
        evt_mask <= w_data[4:0];
    end
  end

  // priority registers; unused b bits store but steer nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      priority_level_a <= `EIFP_RST_BYTE;
      priority_level_b <= `EIFP_RST_BYTE;
    end
    else if (wr_lane0)
    begin
      if (reg_hit(aw_addr, `EIFP_IDX_PRIO_A))
        priority_level_a <= w_data[7:0];
      if (reg_hit(aw_addr, `EIFP_IDX_PRIO_B))
        priority_level_b <= w_data[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flag channels
  assign chif.sense     = ext_request_sense_sel;
  assign chif.line_sync = line_sync;
  assign chif.exc_ack   = exc_ack;
  assign chif.rd_strobe = rd_fire && reg_hit(s_axi_araddr, `EIFP_IDX_FLAGS);
  // only a write of 0 clears; a 1 written leaves the flag alone
  assign chif.wr_strobe = wr_lane0 && reg_hit(aw_addr,
                                              `EIFP_IDX_FLAGS);
  assign chif.wr_data   = w_data[4:0];
  assign ext_request_flag = chif.flag;
  eifp_flags u_flags
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ch      (chif.chan)
  );

  //////////////////////////////////////////////////////////////////////
  // event status: sticky, cleared by reading it, new events win
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_status <= `EIFP_RST_CHAN;
    else if (rd_fire && reg_hit(s_axi_araddr, `EIFP_IDX_EVT_STAT))
      evt_status <= chif.set_evt;
    else
      evt_status <= evt_status | chif.set_evt;
  end

  // one level interrupt while an unmasked event bit is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_out <= 1'b0;
    else
      irq_out <= |(evt_status & evt_mask);
  end

  //////////////////////////////////////////////////////////////////////
  // axi read channel: one read at a time, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_mapped     = reg_mapped(s_axi_araddr);

  // read mux; unmapped addresses and bits 7..5 of the channel registers read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_hit(s_axi_araddr, `EIFP_IDX_SENSE))
      next_rdata = {3'b000, ext_request_sense_sel};
    else if (reg_hit(s_axi_araddr, `EIFP_IDX_ENABLE))
      next_rdata = {3'b000, ext_request_enable};
    else if (reg_hit(s_axi_araddr, `EIFP_IDX_FLAGS))
      next_rdata = {3'b000, ext_request_flag};
    else if (reg_hit(s_axi_araddr, `EIFP_IDX_PRIO_A))
      next_rdata = priority_level_a;
    else if (reg_hit(s_axi_araddr, `EIFP_IDX_PRIO_B))
      next_rdata = priority_level_b;
    else if (reg_hit(s_axi_araddr, `EIFP_IDX_EVT_STAT))
      next_rdata = {3'b000, evt_status};
    else if (reg_hit(s_axi_araddr, `EIFP_IDX_EVT_MASK))
      next_rdata = {3'b000, evt_mask};
  end

  // registered read answer, held until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= EIFP_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, next_rdata};
      s_axi_rresp  <= rd_mapped ? EIFP_RESP_OKAY : EIFP_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // requests and priorities toward the cpu; registered for clean timing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_req  <= `EIFP_RST_CHAN;
      irq_prio <= `EIFP_RST_CHAN;
    end
    else
    begin
      irq_req  <= ext_request_flag & ext_request_enable;
      // channels 2 and 3 share one priority bit
      irq_prio <= {priority_level_a[`EIFP_PA_CH4],
                   priority_level_a[`EIFP_PA_CH23],
                   priority_level_a[`EIFP_PA_CH23],
                   priority_level_a[`EIFP_PA_CH1],
                   priority_level_a[`EIFP_PA_CH0]};
    end
  end

  // priority levels of the other on-chip sources
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      watchdog_source_prio       <= 1'b0;
      timer_unit_source_prio     <= `EIFP_RST_CHAN;
      serial_channel_source_prio <= 1'b0;
      converter_source_prio      <= 1'b0;
    end
    else
    begin
      watchdog_source_prio <= priority_level_a[`EIFP_PA_WDOG];
      timer_unit_source_prio <= {priority_level_b[`EIFP_PB_TMR4],
        priority_level_b[`EIFP_PB_TMR3], priority_level_a[`EIFP_PA_TMR2],
        priority_level_a[`EIFP_PA_TMR1],
        priority_level_a[`EIFP_PA_TMR0]};
      serial_channel_source_prio <=
        priority_level_b[`EIFP_PB_SERIAL];
      converter_source_prio <= priority_level_b[`EIFP_PB_CONV];
    end
  end
endmodule
`default_nettype wire

// *** inc/eifp_chan_if.sv ***
// carrier between the register side and the per-channel flag logic
`timescale 1ns/1ps
`default_nettype none
interface eifp_chan_if;
  import eifp_pkg::*;
  eifp_chan_type sense;
  eifp_chan_type line_sync;
  eifp_chan_type exc_ack;
  logic          rd_strobe;
  logic          wr_strobe;
  eifp_chan_type wr_data;
  eifp_chan_type flag;
  eifp_chan_type set_evt;
  modport ctrl (output sense, line_sync, exc_ack, rd_strobe, wr_strobe,
                output wr_data, input flag, set_evt);
  modport chan (input sense, line_sync, exc_ack, rd_strobe, wr_strobe,
                input wr_data, output flag, set_evt);
endinterface
`default_nettype wire

// *** inc/eifp_defs.svh ***
// register indices, field positions and reset values of the irq block
`ifndef EIFP_DEFS_SVH
`define EIFP_DEFS_SVH

// register indices; byte address is four times the index
`define EIFP_IDX_SENSE     8'hF4
`define EIFP_IDX_ENABLE    8'hF5
`define EIFP_IDX_FLAGS     8'hF6
`define EIFP_IDX_PRIO_A    8'hF8
`define EIFP_IDX_PRIO_B    8'hF9
`define EIFP_IDX_EVT_STAT  8'hFA
`define EIFP_IDX_EVT_MASK  8'hFB

// address bits that carry the index
`define EIFP_ADDR_MSB      9
`define EIFP_ADDR_LSB      2

// number of external request channels
`define EIFP_NCH           5

// priority a field positions
`define EIFP_PA_CH0        7
`define EIFP_PA_CH1        6
`define EIFP_PA_CH23       5
`define EIFP_PA_CH4        4
`define EIFP_PA_WDOG       3
`define EIFP_PA_TMR0       2
`define EIFP_PA_TMR1       1
`define EIFP_PA_TMR2       0

// priority b field positions
`define EIFP_PB_TMR3       7
`define EIFP_PB_TMR4       6
`define EIFP_PB_SERIAL     3
`define EIFP_PB_CONV       1

// reset values
`define EIFP_RST_BYTE      8'h00
`define EIFP_RST_CHAN      5'h00
`define EIFP_RST_LINE      5'h1F

`endif

// *** inc/eifp_pkg.sv ***
// types shared by the irq flag and priority block
package eifp_pkg;
  typedef logic [4:0] eifp_chan_type;
  typedef logic [7:0] eifp_byte_type;
  typedef enum logic [1:0]
  {
    EIFP_RESP_OKAY   = 2'b00,
    EIFP_RESP_SLVERR = 2'b10
  } eifp_resp_type;
endpackage

// *** verif/eifp_assertions.sv ***
// concurrent checks on the irq block ports
`timescale 1ns/1ps
`default_nettype none
module eifp_assertions
(
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire eifp_pkg::eifp_resp_type s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire eifp_pkg::eifp_resp_type s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire eifp_pkg::eifp_chan_type ext_request_line_n,
  input wire eifp_pkg::eifp_chan_type exc_ack,
  input wire eifp_pkg::eifp_chan_type irq_req,
  input wire eifp_pkg::eifp_chan_type irq_prio,
  input wire logic                    irq_out
);
  import eifp_pkg::*;
  // one domain, so one clocking and one reset for all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // responses stand until taken
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed");
  // answer latencies of this slave
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  // unmapped reads carry no data; only lane 0 holds data
  a_slverr_empty: assert property (s_axi_rvalid
    && s_axi_rresp == EIFP_RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carried data");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("upper read bits set");
  a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
    else $error("ready while answer pending");
  a_shared_prio: assert property (irq_prio[2] == irq_prio[3])
    else $error("channels 2 and 3 differ in priority");
  a_reset_quiet: assert property ($rose(aresetn) |-> irq_req == '0
    && !irq_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  // an ack with a steady high pin leaves nothing to set the flag again
  for (genvar i = 0; i < 5; i++)
  begin : g_ack
    a_ack_clears: assert property (exc_ack[i]
      && $past(ext_request_line_n[i]) && $past(ext_request_line_n[i], 2)
      && $past(ext_request_line_n[i], 3) |-> ##3 !irq_req[i])
      else $error("ack left request standing");
  end
endmodule
bind eifp_top eifp_assertions u_chk
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .ext_request_line_n, .exc_ack,
  .irq_req, .irq_prio, .irq_out
);
`default_nettype wire

// *** verif/eifp_far_end.sv ***
// far side model: request pins and cpu acknowledge
`timescale 1ns/1ps
`default_nettype none
module eifp_far_end
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire eifp_pkg::eifp_chan_type line_cmd,
  input  wire logic                    ack_en,
  input  wire logic [3:0]              ack_gap,
  input  wire eifp_pkg::eifp_chan_type irq_req,
  output eifp_pkg::eifp_chan_type      line_n,
  output eifp_pkg::eifp_chan_type      exc_ack
);
  import eifp_pkg::*;
  logic [3:0] gap;
  // pins idle high by pull-up, low while a request is commanded
  assign line_n = ~line_cmd;
  // cpu acks the lowest pending channel; a gap makes it slow
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap <= '0;
      exc_ack <= '0;
    end
    else if (gap != '0)
    begin
      gap <= gap - 4'h1;
      exc_ack <= '0;
    end
    else if (ack_en && irq_req != '0 && exc_ack == '0)
    begin
      exc_ack <= irq_req & (~irq_req + 5'h01);
      gap <= ack_gap;
    end
    else
      exc_ack <= '0;
  end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the irq flag and priority block
`timescale 1ns/1ps
`default_nettype none
`include "eifp_defs.svh"
module tb;
  import eifp_pkg::*;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [31:0]   s_axi_awaddr = '0;
  logic [31:0]   s_axi_wdata = '0;
  logic [31:0]   s_axi_araddr = '0;
  logic [3:0]    s_axi_wstrb = 4'hF;
  logic          s_axi_awvalid = 1'b0;
  logic          s_axi_wvalid = 1'b0;
  logic          s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0;
  logic          s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic          s_axi_arready, s_axi_rvalid, irq_out;
  logic [31:0]   s_axi_rdata;
  eifp_resp_type s_axi_bresp, s_axi_rresp;
  eifp_chan_type ext_request_line_n, exc_ack, irq_req, irq_prio;
  eifp_chan_type line_cmd = '0;
  logic          ack_en = 1'b0;
  logic [3:0]    ack_gap = 4'h0;
  logic          watchdog_source_prio, serial_channel_source_prio;
  logic          converter_source_prio;
  logic [4:0]    timer_unit_source_prio;
  int            miscompares = 0;
  int            checks = 0;
  logic [7:0]    regs [7] = '{`EIFP_IDX_SENSE, `EIFP_IDX_ENABLE,
    `EIFP_IDX_FLAGS, `EIFP_IDX_PRIO_A, `EIFP_IDX_PRIO_B,
    `EIFP_IDX_EVT_STAT, `EIFP_IDX_EVT_MASK};
  ////////////////////////////////////////
  // 50 mhz system clock
  always #10 aclk = ~aclk;
  eifp_top DUT
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_request_line_n, .exc_ack,
    .irq_req, .irq_prio, .watchdog_source_prio, .timer_unit_source_prio,
    .serial_channel_source_prio, .converter_source_prio, .irq_out
  );
  eifp_far_end u_far
  (
    .aclk, .aresetn, .line_cmd, .ack_en, .ack_gap, .irq_req,
    .line_n(ext_request_line_n), .exc_ack
  );
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ends at a falling edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // far side controls change just after a rising edge
  task automatic drv(input eifp_chan_type l, input logic ae,
                     input logic [3:0] g);
    @(posedge aclk);
    line_cmd <= l;
    ack_en <= ae;
    ack_gap <= g;
  endtask
  // readies are sampled at the falling edge, valid drops after the take
  task automatic wr(input logic [7:0] idx, d, input eifp_resp_type er);
    int n;
    logic a, w, b;
    eifp_resp_type rs;
    n = 0;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 50)
    begin
      @(negedge aclk);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (a)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b)
    begin
      miscompares++;
      print_verdict();
    end
    chk("bresp", 32'(er), 32'(rs));
  endtask
  task automatic rd(input logic [7:0] idx, e, input eifp_resp_type er);
    int n;
    logic a, r;
    logic [31:0] g;
    eifp_resp_type rs;
    n = 0;
    r = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 50)
    begin
      @(negedge aclk);
      a = s_axi_arready;
      r = s_axi_rvalid;
      g = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (a)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r)
    begin
      miscompares++;
      print_verdict();
    end
    chk("rresp", 32'(er), 32'(rs));
    chk("rdata", {24'h0, e}, g);
  endtask
  // priority bits read back and reach their source outputs
  task automatic prio(input logic [7:0] a, b);
    wr(`EIFP_IDX_PRIO_A, a, EIFP_RESP_OKAY);
    wr(`EIFP_IDX_PRIO_B, b, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_PRIO_A, a, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_PRIO_B, b, EIFP_RESP_OKAY);
    tick(1);
    chk("irq_prio", 32'({a[4], a[5], a[5], a[6], a[7]}),
        32'(irq_prio));
    chk("wdog", 32'(a[3]), 32'(watchdog_source_prio));
    chk("timer", 32'({b[6], b[7], a[0], a[1], a[2]}),
        32'(timer_unit_source_prio));
    chk("serial", 32'(b[3]), 32'(serial_channel_source_prio));
    chk("conv", 32'(b[1]), 32'(converter_source_prio));
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i])
      rd(regs[i], 8'h00, EIFP_RESP_OKAY);
    rd(8'hFC, 8'h00, EIFP_RESP_SLVERR);
    wr(8'hFC, 8'h55, EIFP_RESP_SLVERR);
    wr(`EIFP_IDX_FLAGS, 8'hFF, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_FLAGS, 8'h00, EIFP_RESP_OKAY);
    prio(8'hA5, 8'hFF);
    prio(8'h5A, 8'h00);
    wr(`EIFP_IDX_ENABLE, 8'h1D, EIFP_RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(`EIFP_IDX_ENABLE, 8'h00, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_ENABLE, 8'h1D, EIFP_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    wr(`EIFP_IDX_EVT_MASK, 8'h02, EIFP_RESP_OKAY);
    drv(5'h01, 1'b0, 4'h0);
    tick(8);
    chk("irq_req", 32'h01, 32'(irq_req));
    chk("irq_out", 32'h0, 32'(irq_out));
    drv(5'h03, 1'b0, 4'h0);
    tick(8);
    chk("irq_req", 32'h01, 32'(irq_req));
    chk("irq_out", 32'h1, 32'(irq_out));
    rd(`EIFP_IDX_EVT_STAT, 8'h03, EIFP_RESP_OKAY);
    tick(2);
    chk("irq_out", 32'h0, 32'(irq_out));
    drv(5'h00, 1'b0, 4'h0);
    tick(8);
    wr(`EIFP_IDX_FLAGS, 8'h00, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_FLAGS, 8'h03, EIFP_RESP_OKAY);
    wr(`EIFP_IDX_FLAGS, 8'h1E, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_FLAGS, 8'h02, EIFP_RESP_OKAY);
    wr(`EIFP_IDX_FLAGS, 8'h00, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_FLAGS, 8'h00, EIFP_RESP_OKAY);
    wr(`EIFP_IDX_SENSE, 8'h1F, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_SENSE, 8'h1F, EIFP_RESP_OKAY);
    drv(5'h04, 1'b0, 4'h0);
    tick(8);
    chk("irq_req", 32'h04, 32'(irq_req));
    drv(5'h04, 1'b1, 4'h3);
    tick(12);
    chk("irq_req", 32'h00, 32'(irq_req));
    rd(`EIFP_IDX_FLAGS, 8'h00, EIFP_RESP_OKAY);
    drv(5'h00, 1'b0, 4'h0);
    tick(4);
    wr(`EIFP_IDX_SENSE, 8'h00, EIFP_RESP_OKAY);
    drv(5'h10, 1'b1, 4'h0);
    tick(12);
    chk("irq_req", 32'h10, 32'(irq_req));
    drv(5'h00, 1'b1, 4'h0);
    tick(12);
    chk("irq_req", 32'h00, 32'(irq_req));
    drv(5'h01, 1'b0, 4'h0);
    tick(8);
    rd(`EIFP_IDX_FLAGS, 8'h01, EIFP_RESP_OKAY);
    wr(`EIFP_IDX_FLAGS, 8'h00, EIFP_RESP_OKAY);
    rd(`EIFP_IDX_FLAGS, 8'h01, EIFP_RESP_OKAY);
    print_verdict();
  end
endmodule
`default_nettype wire
